// ### rtl/irq_consts.svh
// constants for the interrupt entry and exit block
// assumes inclusion by bare name from rtl files
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// --------------------------------
// register byte offsets
// --------------------------------
`define OFS_STATUS 8'h00
`define OFS_ENABLE 8'h04
`define OFS_FLAGS 8'h08
`define OFS_STATE 8'h0C

// --------------------------------
// field positions and reset values
// --------------------------------
`define GIE_BIT 7
`define STATE_SP_POS 16
`define STATE_ST_POS 28
`define STATUS_RST 8'h00
`define VEC_STRIDE 1

// --------------------------------
// timing counts in cpu clocks
// --------------------------------
`define ENTRY_CYC 4
`define SLEEP_EXTRA 4
`define RET_CYC 4
`define JUMP_CYC 3

`endif

// ### rtl/irq_pkg.sv
// types shared by the interrupt entry and exit block
// assumes nothing of its surroundings
`default_nettype none
package irq_pkg;

   // --------------------------------
   // sequencer states
   // --------------------------------
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_ENTRY = 2'b01,
      ST_JUMP = 2'b10,
      ST_RET = 2'b11
   } seq_e;

   // --------------------------------
   // lowest set bit, 32 when none
   // --------------------------------
   function automatic int unsigned first_set(input logic [31:0] v);
      int unsigned r;
      r = 32;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            r = i;
         end
      end
      return r;
   endfunction

endpackage
`default_nettype wire

// ### rtl/irq_link_if.sv
// links the sequencer with its selector and stack memory
// assumes one clock shared by all three modules
`timescale 1ns/100ps
`default_nettype none
interface irq_link_if #(
   parameter int NSRC = 8,
   parameter int SP_W = 9
);
   localparam int IDX_W = $clog2(NSRC);
   logic [NSRC-1:0] pend;
   logic sel_valid;
   logic [IDX_W-1:0] sel_idx;
   logic st_we;
   logic [SP_W-1:0] st_addr;
   logic [7:0] st_wdata;
   logic [7:0] st_rdata;

   modport ctrl(output pend, input sel_valid, input sel_idx,
                output st_we, output st_addr, output st_wdata, input st_rdata);
   modport selector(input pend, output sel_valid, output sel_idx);
   modport stack(input st_we, input st_addr, input st_wdata, output st_rdata);
endinterface
`default_nettype wire

// ### rtl/irq_select.sv
// priority pick among pending enabled sources
// assumes lower index means higher priority
`timescale 1ns/100ps
`default_nettype none
module irq_select import irq_pkg::*; #(
   parameter int NSRC = 8
) (
   irq_link_if.selector link
);
   localparam int IDX_W = $clog2(NSRC);

   // --------------------------------
   // lowest index wins
   // --------------------------------
   always_comb begin
      link.sel_valid = |link.pend;
      link.sel_idx = IDX_W'(first_set(32'(link.pend)));
   end
endmodule
`default_nettype wire

// ### rtl/stack_mem.sv
// byte stack memory for return addresses
// assumes the sequencer holds address for one cycle per access
`timescale 1ns/100ps
`default_nettype none
module stack_mem #(
   parameter int SP_W = 9
) (
   input wire logic clk_in,
   irq_link_if.stack link
);
   logic [7:0] mem [0:(1<<SP_W)-1];
   logic [7:0] rdata_ff;

   // --------------------------------
   // write port and registered read
   // --------------------------------
   always_ff @(posedge clk_in) begin
      if (link.st_we) begin
         mem[link.st_addr] <= link.st_wdata;
      end
      rdata_ff <= mem[link.st_addr];
   end

   assign link.st_rdata = rdata_ff;
endmodule
`default_nettype wire

// ### rtl/cpu_interrupt_entry_exit.sv
// interrupt entry and exit sequencer with ahb-lite registers
// assumes the core pulses boundary_in at each instruction end
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "irq_consts.svh"

// What this block does
// - take a source only if its enable and the global enable are both set
// - vectors sit lowest in program space; lower address means higher priority
// - accepting an interrupt clears the global enable
// - software may set global enable inside a handler to allow nesting
// - return from handler sets the global enable
// - hardware clears a flag source when vectoring to its handler
// - writing one clears a flag, writing zero leaves it
// - events set flags even while disabled; flags stay until served or cleared
// - flags held while globally disabled are served later in priority order
// - level sources request only while their condition stands
// - after return one instruction runs before the next interrupt
// - the status flags are neither saved nor restored
// - the disable instruction blocks even a same-cycle request
// - after the enable instruction the next instruction runs first
// - entry takes four clocks pushing the pc, then the vector runs
// - a multi-cycle instruction finishes before entry starts
// - waking from sleep adds four clocks to entry
// - return takes four clocks, pops two pc bytes, sp plus two
// - the jump at the vector takes three clocks
// - the pc is 10, 11 or 12 bits of word address
// - pushing the return address lowers sp by two
module cpu_interrupt_entry_exit import irq_pkg::*; #(
   parameter int NSRC = 8,
   parameter int PC_W = 12,
   parameter int SP_W = 9,
   parameter logic [SP_W-1:0] SP_RESET = '1,
   parameter logic [NSRC-1:0] LEVEL_MASK = '0,
   localparam int IDX_W = $clog2(NSRC)
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // ahb-lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // interrupt sources
   input wire logic [NSRC-1:0] event_in,
   input wire logic [NSRC-1:0] level_in,
   // core pipeline
   input wire logic boundary_in,
   input wire logic sei_in,
   input wire logic cli_in,
   input wire logic return_from_handler_in,
   input wire logic asleep_in,
   input wire logic [PC_W-1:0] next_pc_in,
   input wire logic [PC_W-1:0] jump_target_in,
   output logic stall_out,
   output logic vector_out,
   output logic redirect_out,
   output logic ie_out,
   output logic [PC_W-1:0] pc_out,
   output logic [SP_W-1:0] sp_out,
   output logic [IDX_W-1:0] src_out
);

   // --------------------------------
   // reset release
   // --------------------------------
   logic rst_meta_ff;
   logic rst_sync_ff;
   logic rstn;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   assign rstn = rst_sync_ff;

   // --------------------------------
   // declarations
   // --------------------------------
   irq_link_if #(.NSRC(NSRC), .SP_W(SP_W)) link();

   seq_e st_ff;
   seq_e nxt_st;
   logic [3:0] cnt_ff;
   logic [3:0] len_ff;
   logic [7:0] status_ff;
   logic [NSRC-1:0] en_ff;
   logic [NSRC-1:0] flag_ff;
   logic [NSRC-1:0] nxt_flag;
   logic [PC_W-1:0] pc_ff;
   logic [PC_W-1:0] ret_pc_ff;
   logic [SP_W-1:0] sp_ff;
   logic [IDX_W-1:0] src_ff;
   logic [7:0] pop_hi_ff;
   logic [7:0] pop_lo_ff;
   logic stall_ff;
   logic vector_ff;
   logic redirect_ff;
   logic [31:0] hrdata_ff;
   logic dp_wr_ff;
   logic [7:0] dp_addr_ff;
   logic ap_take;
   logic at_boundary;
   logic start_entry;
   logic return_from_handler_take;
   logic entry_last;
   logic jump_last;
   logic ret_last;
   logic [NSRC-1:0] clr_hw;
   logic [NSRC-1:0] clr_sw;
   logic [NSRC-1:0] req_vec;

   irq_select #(.NSRC(NSRC)) u_select (
      .link(link)
   );

   stack_mem #(.SP_W(SP_W)) u_stack (
      .clk_in(clk_in),
      .link(link)
   );

   // --------------------------------
   // request gathering
   // --------------------------------
   always_comb begin
      req_vec = (flag_ff & ~LEVEL_MASK) | (level_in & LEVEL_MASK);
      link.pend = req_vec & en_ff;
   end

   // asleep core has no instruction in flight; else wait for its end
   assign at_boundary = asleep_in || boundary_in;
   // pc load cycle after a redirect runs no instruction
   assign start_entry = (st_ff == ST_RUN) && at_boundary && status_ff[`GIE_BIT] &&
                        !redirect_ff &&
                        !cli_in && !sei_in && !return_from_handler_in && link.sel_valid;
   assign return_from_handler_take = (st_ff == ST_RUN) && boundary_in && return_from_handler_in && !asleep_in;
   assign entry_last = (st_ff == ST_ENTRY) && (cnt_ff == len_ff - 4'h1);
   assign jump_last = (st_ff == ST_JUMP) && (cnt_ff == 4'(`JUMP_CYC - 1));
   assign ret_last = (st_ff == ST_RET) && (cnt_ff == 4'(`RET_CYC - 1));

   // --------------------------------
   // sequencer
   // --------------------------------
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_RUN: begin
            if (start_entry) begin
               nxt_st = ST_ENTRY;
            end else if (return_from_handler_take) begin
               nxt_st = ST_RET;
            end
         end
         ST_ENTRY: begin
            if (entry_last) begin
               nxt_st = ST_JUMP;
            end
         end
         ST_JUMP: begin
            if (jump_last) begin
               nxt_st = ST_RUN;
            end
         end
         ST_RET: begin
            if (ret_last) begin
               nxt_st = ST_RUN;
            end
         end
         default: begin
            nxt_st = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) begin
         st_ff <= ST_RUN;
         cnt_ff <= 4'h0;
         len_ff <= 4'(`ENTRY_CYC);
         stall_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         stall_ff <= (nxt_st != ST_RUN);
         if (nxt_st != st_ff) begin
            cnt_ff <= 4'h0;
         end else begin
            cnt_ff <= cnt_ff + 4'h1;
         end
         if (start_entry) begin
            len_ff <= asleep_in ? 4'(`ENTRY_CYC + `SLEEP_EXTRA) : 4'(`ENTRY_CYC);
         end
      end
   end

   // --------------------------------
   // stack port
   // --------------------------------
   always_comb begin
      link.st_we = 1'b0;
      link.st_addr = sp_ff;
      link.st_wdata = 8'h00;
      case (st_ff)
         ST_ENTRY: begin
            if (cnt_ff == 4'h0) begin
               link.st_we = 1'b1;
               link.st_wdata = ret_pc_ff[7:0];
            end else if (cnt_ff == 4'h1) begin
               link.st_we = 1'b1;
               link.st_addr = SP_W'(sp_ff - 1);
               link.st_wdata = 8'(ret_pc_ff >> 8);
            end
         end
         ST_RET: begin
            link.st_addr = (cnt_ff == 4'h0) ? SP_W'(sp_ff + 1) : SP_W'(sp_ff + 2);
         end
         default: begin
            link.st_we = 1'b0;
         end
      endcase
   end

   // --------------------------------
   // pc, sp and source tracking
   // --------------------------------
   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) begin
         pc_ff <= '0;
         ret_pc_ff <= '0;
         sp_ff <= SP_RESET;
         src_ff <= '0;
         pop_hi_ff <= 8'h00;
         pop_lo_ff <= 8'h00;
         vector_ff <= 1'b0;
         redirect_ff <= 1'b0;
      end else begin
         vector_ff <= entry_last;
         redirect_ff <= jump_last || ret_last;
         if (start_entry) begin
            ret_pc_ff <= next_pc_in;
            src_ff <= link.sel_idx;
         end
         if (entry_last) begin
            sp_ff <= SP_W'(sp_ff - 2);
            pc_ff <= PC_W'((32'(src_ff) + 1) * `VEC_STRIDE);
         end
         if (jump_last) begin
            pc_ff <= jump_target_in;
         end
         if (st_ff == ST_RET && cnt_ff == 4'h1) begin
            pop_hi_ff <= link.st_rdata;
         end
         if (st_ff == ST_RET && cnt_ff == 4'h2) begin
            pop_lo_ff <= link.st_rdata;
         end
         if (ret_last) begin
            sp_ff <= SP_W'(sp_ff + 2);
            pc_ff <= PC_W'({pop_hi_ff, pop_lo_ff});
         end
      end
   end

   // --------------------------------
   // ahb-lite slave
   // --------------------------------
   assign ap_take = hsel_in && htrans_in[1] && hready_in;

   function automatic logic [31:0] rd_word(input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         `OFS_STATUS: r = 32'(status_ff);
         `OFS_ENABLE: r = 32'(en_ff);
         `OFS_FLAGS: r = 32'(flag_ff);
         `OFS_STATE: r = 32'(pc_ff) | (32'(sp_ff) << `STATE_SP_POS) | (32'(st_ff) << `STATE_ST_POS);
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) begin
         dp_wr_ff <= 1'b0;
         dp_addr_ff <= 8'h00;
         hrdata_ff <= 32'h0000_0000;
      end else begin
         dp_wr_ff <= ap_take && hwrite_in;
         if (ap_take) begin
            dp_addr_ff <= haddr_in[7:0];
         end
         if (ap_take && !hwrite_in) begin
            hrdata_ff <= rd_word(haddr_in[7:0]);
         end
      end
   end

   // --------------------------------
   // status flags, enables, flags
   // --------------------------------
   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) begin
         status_ff <= `STATUS_RST;
      end else begin
         if (dp_wr_ff && dp_addr_ff == `OFS_STATUS) begin
            status_ff <= hwdata_in[7:0];
         end
         if (start_entry) begin
            status_ff[`GIE_BIT] <= 1'b0;
         end else if (cli_in) begin
            status_ff[`GIE_BIT] <= 1'b0;
         end else if (ret_last || sei_in) begin
            status_ff[`GIE_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) begin
         en_ff <= '0;
      end else if (dp_wr_ff && dp_addr_ff == `OFS_ENABLE) begin
         en_ff <= hwdata_in[NSRC-1:0];
      end
   end

   always_comb begin
      clr_hw = '0;
      if (entry_last) begin
         clr_hw[src_ff] = 1'b1;
      end
      clr_sw = (dp_wr_ff && dp_addr_ff == `OFS_FLAGS) ? hwdata_in[NSRC-1:0] : '0;
      nxt_flag = ((flag_ff & ~clr_hw & ~clr_sw) | event_in) & ~LEVEL_MASK;
   end

   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) begin
         flag_ff <= '0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   // --------------------------------
   // outputs
   // --------------------------------
   assign hrdata_out = hrdata_ff;
   assign hreadyout_out = rstn;
   assign hresp_out = 1'b0;
   assign stall_out = stall_ff;
   assign vector_out = vector_ff;
   assign redirect_out = redirect_ff;
   assign ie_out = status_ff[`GIE_BIT];
   assign pc_out = pc_ff;
   assign sp_out = sp_ff;
   assign src_out = src_ff;

   // --------------------------------
   // checks
   // --------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn);

   chk_take_enabled: assert property (
      start_entry |-> status_ff[`GIE_BIT] && en_ff[link.sel_idx])
      else $error("entry taken without both enables");
   chk_prio_lowest: assert property (
      start_entry |-> (32'(link.pend) & ((32'h1 << link.sel_idx) - 32'h1)) == 32'h0)
      else $error("entry skipped a higher priority source");
   chk_gie_cleared: assert property (
      start_entry |=> !status_ff[`GIE_BIT] && stall_out)
      else $error("global enable not cleared on entry");
   chk_cli_blocks: assert property (
      cli_in |=> st_ff != ST_ENTRY || $past(st_ff) == ST_ENTRY)
      else $error("entry started with disable instruction");
   chk_entry_len: assert property (
      start_entry && !asleep_in |=> (st_ff == ST_ENTRY)[*4] ##1 (st_ff == ST_JUMP && vector_out))
      else $error("entry not four cycles");
   chk_sleep_extra: assert property (
      start_entry && asleep_in |=> (st_ff == ST_ENTRY)[*8] ##1 st_ff == ST_JUMP)
      else $error("sleep entry not eight cycles");
   chk_jump_len: assert property (
      $rose(st_ff == ST_JUMP) |-> (st_ff == ST_JUMP)[*3] ##1 (st_ff == ST_RUN && redirect_out))
      else $error("vector jump not three cycles");
   chk_ret_seq: assert property (
      return_from_handler_take |=> (st_ff == ST_RET)[*4] ##1 (status_ff[`GIE_BIT] && sp_out == SP_W'($past(sp_ff, 5) + 2)))
      else $error("return sequence wrong");
   chk_push_sp: assert property (
      entry_last |=> sp_out == SP_W'($past(sp_ff) - 2))
      else $error("push did not lower sp by two");
   chk_flag_clear: assert property (
      entry_last && !LEVEL_MASK[src_ff] |=> !flag_ff[$past(src_ff)] || $past(event_in[src_ff]))
      else $error("flag not cleared on vectoring");
endmodule
`default_nettype wire

// ### testbench/core_model.sv
// stand-in for the core pipeline: instruction ends, next pc, vector jump
// assumes the bench steers run_in just after rising edges
`timescale 1ns/100ps
`default_nettype none
module core_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // from bench and block
   input wire logic run_in,
   input wire logic stall_in,
   input wire logic redirect_in,
   input wire logic vector_in,
   input wire logic [11:0] pc_in,
   // to block
   output logic boundary_out,
   output logic [11:0] next_pc_out,
   output logic [11:0] jump_target_out
);
   // ----------------------------------------
   // one-cycle instructions unless held
   // ----------------------------------------
   // pc load cycle completes no instruction
   assign boundary_out = run_in & ~stall_in & ~redirect_in;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         next_pc_out <= 12'h040;
      end else if (redirect_in) begin
         next_pc_out <= pc_in + 12'h001;
      end else if (boundary_out) begin
         next_pc_out <= next_pc_out + 12'h001;
      end
   end
   // ----------------------------------------
   // handler a fixed distance past its vector
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         jump_target_out <= 12'h000;
      end else if (vector_in) begin
         jump_target_out <= pc_in + 12'h100;
      end
   end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the interrupt entry and exit block
// assumes core_model stands in for the core pipeline
`timescale 1ns/100ps
`default_nettype none
`include "irq_consts.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic hready, hresp, bnd, stall, vec, redir, ie;
   logic [7:0] ev = 8'h00;
   logic [7:0] lv = 8'h00;
   logic run = 1'b0;
   logic sei = 1'b0;
   logic cli = 1'b0;
   logic return_from_handler = 1'b0;
   logic sleep = 1'b0;
   logic [11:0] npc, jt, pc, last_ret;
   logic [8:0] sp, sp_exp;
   logic [2:0] src;
   logic [11:0] ret_q[$];
   int n_mismatch = 0;
   int checked = 0;

   cpu_interrupt_entry_exit #(.LEVEL_MASK(8'h40)) i_dut (.clk_in(clk), .resetn_in(rst_n),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(hresp), .event_in(ev), .level_in(lv),
      .boundary_in(bnd), .sei_in(sei), .cli_in(cli), .return_from_handler_in(return_from_handler), .asleep_in(sleep),
      .next_pc_in(npc), .jump_target_in(jt), .stall_out(stall), .vector_out(vec),
      .redirect_out(redir), .ie_out(ie), .pc_out(pc), .sp_out(sp), .src_out(src));
   core_model i_core (.clk_in(clk), .resetn_in(rst_n), .run_in(run), .stall_in(stall),
      .redirect_in(redir), .vector_in(vec), .pc_in(pc), .boundary_out(bnd),
      .next_pc_out(npc), .jump_target_out(jt));

   initial begin
      forever #25 clk = ~clk;
   end
   // ----------------------------------------
   // report and bounded waits
   // ----------------------------------------
   task automatic stop_test();
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic fail_out();
      n_mismatch++;
      stop_test();
   endtask
   task automatic bus_wait();
      int n;
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 50) fail_out();
         @(posedge clk);
      end
   endtask
   task automatic wait_hi(ref logic s, output int n);
      n = 0;
      while (s !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > 60) fail_out();
      end
   endtask
   // ----------------------------------------
   // bus cycles and core actions
   // ----------------------------------------
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h000000, a};
      bus_wait();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      bus_wait();
      rd = hrdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      `CHK(rd, e)
      `CHK(hresp, 1'b0)
   endtask
   task automatic src_set(input logic [7:0] e, input logic [7:0] l);
      @(posedge clk);
      ev <= e;
      lv <= l;
      @(posedge clk);
      ev <= 8'h00;
   endtask
   task automatic core(input logic r, input logic s);
      @(posedge clk);
      run <= r;
      sleep <= s;
   endtask
   task automatic op(input logic [2:0] k, input logic r);
      @(posedge clk);
      {sei, cli, return_from_handler} <= k;
      run <= 1'b1;
      @(posedge clk);
      {sei, cli, return_from_handler} <= 3'b000;
      run <= r;
   endtask
   task automatic entry(input logic [2:0] s, input int c);
      int n;
      logic [11:0] rp;
      rp = npc;
      n = 0;
      @(negedge clk);
      while (stall !== 1'b1) begin
         rp = npc;
         @(negedge clk);
         n++;
         if (n > 60) fail_out();
      end
      ret_q.push_back(rp);
      wait_hi(vec, n);
      `CHK(n, c)
      sp_exp = sp_exp - 9'd2;
      `CHK(src, s)
      `CHK(pc, {9'h000, s} + 12'h001)
      `CHK(ie, 1'b0)
      `CHK(sp, sp_exp)
      wait_hi(redir, n);
      `CHK(n, `JUMP_CYC)
      `CHK(pc, {9'h000, s} + 12'h101)
      `CHK(stall, 1'b0)
   endtask
   task automatic leave();
      int n;
      op(3'b001, 1'b1);
      wait_hi(stall, n);
      wait_hi(redir, n);
      `CHK(n, `RET_CYC)
      sp_exp = sp_exp + 9'd2;
      last_ret = ret_q.pop_back();
      `CHK(pc, last_ret)
      `CHK(sp, sp_exp)
      `CHK(ie, 1'b1)
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      sp_exp = 9'h1FF;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk(`OFS_STATUS, 32'h0);
      rd_chk(`OFS_STATE, 32'h01FF0000);
      rd_chk(8'h10, 32'h0);
      src_set(8'h08, 8'h00);
      rd_chk(`OFS_FLAGS, 32'h08);
      ahb(1'b1, `OFS_FLAGS, 32'hF7);
      rd_chk(`OFS_FLAGS, 32'h08);
      ahb(1'b1, `OFS_FLAGS, 32'h08);
      rd_chk(`OFS_FLAGS, 32'h00);
      src_set(8'h24, 8'h00);
      run <= 1'b1;
      ahb(1'b1, `OFS_ENABLE, 32'h24);
      ahb(1'b1, `OFS_STATUS, 32'h05);
      repeat (8) @(negedge clk);
      `CHK(stall, 1'b0)
      ahb(1'b1, `OFS_ENABLE, 32'h00);
      ahb(1'b1, `OFS_STATUS, 32'h85);
      repeat (8) @(negedge clk);
      `CHK(stall, 1'b0)
      ahb(1'b1, `OFS_ENABLE, 32'h24);
      entry(3'd2, `ENTRY_CYC);
      rd_chk(`OFS_FLAGS, 32'h20);
      leave();
      entry(3'd5, `ENTRY_CYC);
      `CHK(ret_q[$] > last_ret, 1'b1)
      rd_chk(`OFS_STATUS, 32'h05);
      src_set(8'h04, 8'h00);
      ahb(1'b1, `OFS_STATUS, 32'h85);
      entry(3'd2, `ENTRY_CYC);
      leave();
      leave();
      rd_chk(`OFS_STATUS, 32'h85);
      ahb(1'b1, `OFS_STATUS, 32'h05);
      ahb(1'b1, `OFS_ENABLE, 32'h2C);
      src_set(8'h08, 8'h00);
      op(3'b100, 1'b1);
      @(negedge clk);
      `CHK(stall, 1'b0)
      entry(3'd3, `ENTRY_CYC);
      leave();
      core(1'b0, 1'b0);
      src_set(8'h08, 8'h00);
      ahb(1'b1, `OFS_STATUS, 32'h85);
      repeat (6) @(negedge clk);
      `CHK(stall, 1'b0)
      op(3'b100, 1'b0);
      @(negedge clk);
      `CHK(stall, 1'b0)
      op(3'b010, 1'b0);
      repeat (6) @(negedge clk);
      `CHK(stall, 1'b0)
      `CHK(ie, 1'b0)
      ahb(1'b1, `OFS_STATUS, 32'h85);
      core(1'b0, 1'b1);
      entry(3'd3, `ENTRY_CYC + `SLEEP_EXTRA);
      core(1'b1, 1'b0);
      leave();
      src_set(8'h00, 8'h40);
      src_set(8'h00, 8'h00);
      ahb(1'b1, `OFS_ENABLE, 32'h6C);
      repeat (8) @(negedge clk);
      `CHK(stall, 1'b0)
      src_set(8'h00, 8'h40);
      entry(3'd6, `ENTRY_CYC);
      src_set(8'h00, 8'h00);
      leave();
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_out();
   end
endmodule
`default_nettype wire
